/* verilog/fos_defs.svh */
// Register map, field positions, reset values and timing counts of the flash sequencer
`ifndef FOS_DEFS_SVH
`define FOS_DEFS_SVH

// Register byte offsets
`define FOS_CTRL_OFF 12'h000
`define FOS_TEST_OFF 12'h004
`define FOS_WAIT_OFF 12'h008
`define FOS_ISTAT_OFF 12'h00c
`define FOS_IMASK_OFF 12'h010

// Control register fields
`define FOS_HV_BIT 0
`define FOS_OP_LSB 1
`define FOS_BSIZE_LSB 4
`define FOS_LPWR_BIT 6
`define FOS_DONE_BIT 7
`define FOS_READY_BIT 8

// Integrity test register fields
`define FOS_AIE_BIT 0
`define FOS_SUS_BIT 1
`define FOS_BPC_BIT 2
`define FOS_ALT_BIT 3
`define FOS_MR_BIT 4
`define FOS_BPEN_BIT 5
`define FOS_AID_BIT 6
`define FOS_NREAD_LSB 8

// Reset values
`define FOS_RWS_RST 3'h7
`define FOS_NREAD_RST 4'h1

// Interrupt bits
`define FOS_IRQ_OP 0
`define FOS_IRQ_AI 1
`define FOS_IRQ_RCV 2

// Clock
`define FOS_CLK_NS 10
`define FOS_CLK_MHZ 100

// Abort: least 5 us plus four clocks
`define FOS_ABORT_NS 5000
`define FOS_ABORT_CYC ((`FOS_ABORT_NS + `FOS_CLK_NS - 1) / `FOS_CLK_NS + 4)
// Low-power exit recovery: typical 17.5 us plus seven clocks
`define FOS_RECOV_NS 17500
`define FOS_RECOV_CYC (`FOS_RECOV_NS / `FOS_CLK_NS + 7)
// Integrity check stop: at most 50 clocks
`define FOS_AI_STOP_CYC 50
// Margin read stop: at most 26 us plus fifteen clocks
`define FOS_MR_STOP_NS 26000
`define FOS_MR_STOP_CYC (`FOS_MR_STOP_NS / `FOS_CLK_NS + 15)
// Margin read adder of 40 us
`define FOS_MR_ADD_NS 40000
`define FOS_MR_ADD_CYC (`FOS_MR_ADD_NS / `FOS_CLK_NS)

// Operation times in microsecond ticks, and the quad page repeat count of a sector program
`define FOS_DW_US 16'd102
`define FOS_PG_US 16'd142
`define FOS_QP_US 16'd314
`define FOS_QP_PER_SECTOR 6'd63
`define FOS_SERS_US 16'd4800
`define FOS_BERS256_US 16'd22800
`define FOS_BERS512_US 16'd25400
`define FOS_BERS1M_US 16'd30600
`define FOS_BERS2M_US 16'd41100

// Reads per integrity pass
`define FOS_SEQ_N256 25'd8192
`define FOS_ALT_N256 25'd106496
`define FOS_ALT_N512 25'd229376
`define FOS_ALT_N1M 25'd491520
`define FOS_ALT_N2M 25'd1048576

`endif

/* verilog/fos_pkg.sv */
// Types of the flash sequencer
package fos_pkg;

  typedef enum logic [2:0] {
    FOS_OP_DWORD = 3'h0,
    FOS_OP_PAGE = 3'h1,
    FOS_OP_QPAGE = 3'h2,
    FOS_OP_SPGM = 3'h3,
    FOS_OP_SERS = 3'h4,
    FOS_OP_BERS = 3'h5
  } fos_op_t;

  typedef enum logic [4:0] {
    FOS_S_IDLE = 5'h01,
    FOS_S_OP = 5'h02,
    FOS_S_ABORT = 5'h04,
    FOS_S_LPWR = 5'h08,
    FOS_S_RECOV = 5'h10
  } fos_seq_t;

  typedef enum logic [3:0] {
    FOS_A_IDLE = 4'h1,
    FOS_A_RUN = 4'h2,
    FOS_A_STOP = 4'h4,
    FOS_A_HALT = 4'h8
  } fos_ai_t;

  typedef struct packed {
    logic hv;
    fos_op_t op;
    logic [1:0] bsize;
    logic lpwr;
    logic done;
    logic ai_en;
    logic ai_sus;
    logic ai_alt;
    logic ai_mr;
    logic ai_bpen;
    logic ai_done;
    logic ai_abort;
    logic ai_bphit;
    logic [3:0] nread;
    logic [2:0] rws;
    logic [2:0] istat;
    logic [2:0] imask;
    fos_seq_t seq;
    fos_ai_t ai;
    logic [15:0] tdiv;
    logic [15:0] op_cnt;
    logic [5:0] qp_left;
    logic [11:0] cyc;
    logic [24:0] ai_cnt;
    logic [24:0] ai_bp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } fos_state_t;

endpackage

/* verilog/fos_seq.sv */
// Flash program/erase and integrity sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "fos_defs.svh"

module fos_seq #(
  parameter int unsigned TICK_CYC = 100
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  fos_pkg::fos_state_t r;
  fos_pkg::fos_state_t next_r;

  logic wr;
  logic rd_done;
  logic tick;
  logic [2:0] ev;
  logic [24:0] total;
  logic [31:0] rdv;
  logic hit;

  // Operation length in microsecond ticks
  function automatic logic [15:0] op_time(input fos_pkg::fos_op_t op,
                                          input logic [1:0] bs);
    logic [15:0] t;
    t = `FOS_QP_US;
    case (op)
      fos_pkg::FOS_OP_DWORD: t = `FOS_DW_US;
      fos_pkg::FOS_OP_PAGE: t = `FOS_PG_US;
      fos_pkg::FOS_OP_QPAGE: t = `FOS_QP_US;
      fos_pkg::FOS_OP_SPGM: t = `FOS_QP_US;
      fos_pkg::FOS_OP_SERS: t = `FOS_SERS_US;
      fos_pkg::FOS_OP_BERS: begin
        case (bs)
          2'h0: t = `FOS_BERS256_US;
          2'h1: t = `FOS_BERS512_US;
          2'h2: t = `FOS_BERS1M_US;
          default: t = `FOS_BERS2M_US;
        endcase
      end
      default: t = `FOS_QP_US;
    endcase
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational next state

  always_comb begin
    next_r = r;
    ev = 3'h0;
    rdv = 32'h0;
    hit = 1'b1;
    total = 25'h0;
    wr = psel & penable & pready & pwrite;
    rd_done = psel & penable & pready & ~pwrite;
    tick = (r.tdiv == 16'(TICK_CYC - 1));

    // Microsecond time base
    next_r.tdiv = tick ? 16'h0 : r.tdiv + 16'h1;

    // Read decode; unmapped addresses answer with an error
    case (paddr)
      `FOS_CTRL_OFF: begin
        rdv[`FOS_HV_BIT] = r.hv;
        rdv[`FOS_OP_LSB +: 3] = r.op;
        rdv[`FOS_BSIZE_LSB +: 2] = r.bsize;
        rdv[`FOS_LPWR_BIT] = r.lpwr;
        rdv[`FOS_DONE_BIT] = r.done;
        rdv[`FOS_READY_BIT] = (r.seq == fos_pkg::FOS_S_IDLE);
      end
      `FOS_TEST_OFF: begin
        rdv[`FOS_AIE_BIT] = r.ai_en;
        rdv[`FOS_SUS_BIT] = r.ai_sus;
        rdv[`FOS_ALT_BIT] = r.ai_alt;
        rdv[`FOS_MR_BIT] = r.ai_mr;
        rdv[`FOS_BPEN_BIT] = r.ai_bpen;
        rdv[`FOS_AID_BIT] = r.ai_done;
        rdv[`FOS_NREAD_LSB +: 4] = r.nread;
      end
      `FOS_WAIT_OFF: rdv[2:0] = r.rws;
      `FOS_ISTAT_OFF: rdv[2:0] = r.istat;
      `FOS_IMASK_OFF: rdv[2:0] = r.imask;
      default: hit = 1'b0;
    endcase

    // One wait state: pready rises in the second access cycle
    next_r.pready = psel & penable & ~pready;
    if (psel & penable & ~pready) begin
      next_r.prdata = pwrite ? 32'h0 : rdv;
      next_r.pslverr = ~hit;
    end else begin
      // Read data stands only with pready, so stale words never leak to the bus
      next_r.prdata = 32'h0;
      next_r.pslverr = 1'b0;
    end

    // Register writes
    if (wr) begin
      case (paddr)
        `FOS_CTRL_OFF: begin
          next_r.hv = pwdata[`FOS_HV_BIT];
          next_r.lpwr = pwdata[`FOS_LPWR_BIT];
          if (r.seq == fos_pkg::FOS_S_IDLE) begin
            next_r.op = fos_pkg::fos_op_t'(pwdata[`FOS_OP_LSB +: 3]);
            next_r.bsize = pwdata[`FOS_BSIZE_LSB +: 2];
          end
        end
        `FOS_TEST_OFF: begin
          next_r.ai_en = pwdata[`FOS_AIE_BIT];
          next_r.ai_sus = pwdata[`FOS_SUS_BIT];
          next_r.ai_bpen = pwdata[`FOS_BPEN_BIT];
          if (r.ai == fos_pkg::FOS_A_IDLE) begin
            next_r.ai_alt = pwdata[`FOS_ALT_BIT];
            next_r.ai_mr = pwdata[`FOS_MR_BIT];
            next_r.nread = pwdata[`FOS_NREAD_LSB +: 4];
          end
        end
        `FOS_WAIT_OFF: next_r.rws = pwdata[2:0];
        `FOS_IMASK_OFF: next_r.imask = pwdata[2:0];
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // Program / erase sequencer

    case (r.seq)
      fos_pkg::FOS_S_IDLE: begin
        if (next_r.lpwr) begin
          next_r.seq = fos_pkg::FOS_S_LPWR;
        end else if (next_r.hv & ~r.hv) begin
          next_r.done = 1'b0;
          next_r.op_cnt = op_time(next_r.op, next_r.bsize);
          next_r.qp_left = (next_r.op == fos_pkg::FOS_OP_SPGM) ?
                           `FOS_QP_PER_SECTOR : 6'h0;
          next_r.seq = fos_pkg::FOS_S_OP;
        end
      end
      fos_pkg::FOS_S_OP: begin
        if (~next_r.hv) begin
          // Same abort delay for every kind, well inside the block erase allowance
          next_r.cyc = 12'(`FOS_ABORT_CYC);
          next_r.seq = fos_pkg::FOS_S_ABORT;
        end else if (tick) begin
          if (r.op_cnt == 16'h1) begin
            if (r.qp_left != 6'h0) begin
              next_r.qp_left = r.qp_left - 6'h1;
              next_r.op_cnt = `FOS_QP_US;
            end else begin
              next_r.done = 1'b1;
              ev[`FOS_IRQ_OP] = 1'b1;
              next_r.seq = fos_pkg::FOS_S_IDLE;
            end
          end else begin
            next_r.op_cnt = r.op_cnt - 16'h1;
          end
        end
      end
      fos_pkg::FOS_S_ABORT: begin
        next_r.cyc = r.cyc - 12'h1;
        if (r.cyc == 12'h1) begin
          next_r.done = 1'b1;
          ev[`FOS_IRQ_OP] = 1'b1;
          next_r.seq = fos_pkg::FOS_S_IDLE;
        end
      end
      fos_pkg::FOS_S_LPWR: begin
        // Start requests are ignored until recovery is over
        if (~next_r.lpwr) begin
          next_r.cyc = 12'(`FOS_RECOV_CYC);
          next_r.seq = fos_pkg::FOS_S_RECOV;
        end
      end
      fos_pkg::FOS_S_RECOV: begin
        next_r.cyc = r.cyc - 12'h1;
        if (r.cyc == 12'h1) begin
          ev[`FOS_IRQ_RCV] = 1'b1;
          next_r.seq = fos_pkg::FOS_S_IDLE;
        end
      end
      default: next_r.seq = fos_pkg::FOS_S_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////////
    // Margin read and array integrity

    if (next_r.ai_alt) begin
      case (next_r.bsize)
        2'h0: total = `FOS_ALT_N256;
        2'h1: total = `FOS_ALT_N512;
        2'h2: total = `FOS_ALT_N1M;
        default: total = `FOS_ALT_N2M;
      endcase
    end else begin
      total = `FOS_SEQ_N256 << next_r.bsize;
    end
    // A zero read count is taken as one clock per read
    total = 25'(total * ((next_r.nread == 4'h0) ? 25'h1 : 25'(next_r.nread)));
    if (next_r.ai_mr & ~next_r.ai_alt) begin
      total = total + 25'(`FOS_MR_ADD_CYC);
    end

    case (r.ai)
      fos_pkg::FOS_A_IDLE: begin
        if (next_r.ai_en & ~r.ai_en) begin
          next_r.ai_done = 1'b0;
          next_r.ai_cnt = total;
          next_r.ai_bp = total >> 1;
          next_r.ai_bphit = 1'b0;
          next_r.ai = fos_pkg::FOS_A_RUN;
        end
      end
      fos_pkg::FOS_A_RUN: begin
        next_r.ai_cnt = r.ai_cnt - 25'h1;
        if (~next_r.ai_en | next_r.ai_sus) begin
          next_r.ai_abort = ~next_r.ai_en;
          next_r.cyc = (r.ai_mr & ~r.ai_alt) ? 12'(`FOS_MR_STOP_CYC)
                                              : 12'(`FOS_AI_STOP_CYC);
          next_r.ai = fos_pkg::FOS_A_STOP;
        end else if (r.ai_cnt == 25'h1) begin
          next_r.ai_done = 1'b1;
          ev[`FOS_IRQ_AI] = 1'b1;
          next_r.ai = fos_pkg::FOS_A_IDLE;
        end else if (r.ai_bpen & ~r.ai_bphit & (r.ai_cnt == r.ai_bp)) begin
          next_r.ai_bphit = 1'b1;
          next_r.ai_done = 1'b1;
          ev[`FOS_IRQ_AI] = 1'b1;
          next_r.ai = fos_pkg::FOS_A_HALT;
        end
      end
      fos_pkg::FOS_A_STOP: begin
        next_r.cyc = r.cyc - 12'h1;
        if (r.cyc == 12'h1) begin
          next_r.ai_done = 1'b1;
          ev[`FOS_IRQ_AI] = 1'b1;
          next_r.ai = r.ai_abort ? fos_pkg::FOS_A_IDLE : fos_pkg::FOS_A_HALT;
        end
      end
      fos_pkg::FOS_A_HALT: begin
        if (~next_r.ai_en) begin
          next_r.ai = fos_pkg::FOS_A_IDLE;
        end else if ((r.ai_sus & ~next_r.ai_sus) |
                     (wr & (paddr == `FOS_TEST_OFF) & pwdata[`FOS_BPC_BIT] &
                      ~next_r.ai_sus)) begin
          next_r.ai_done = 1'b0;
          next_r.ai = fos_pkg::FOS_A_RUN;
        end
      end
      default: next_r.ai = fos_pkg::FOS_A_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////////
    // Interrupts: a new event wins over the read clear

    for (int i = 0; i < 3; i++) begin
      next_r.istat[i] = ((rd_done & (paddr == `FOS_ISTAT_OFF)) ? 1'b0 : r.istat[i]) | ev[i];
    end
    next_r.irq = |(next_r.istat & next_r.imask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.op <= fos_pkg::FOS_OP_DWORD;
      r.done <= 1'b1;
      r.ai_done <= 1'b1;
      r.nread <= `FOS_NREAD_RST;
      r.rws <= `FOS_RWS_RST;
      r.seq <= fos_pkg::FOS_S_IDLE;
      r.ai <= fos_pkg::FOS_A_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;

endmodule // fos_seq

`default_nettype wire

/* test/fos_seq_checker.sv */
// Bus and done-flag timing checks of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fos_seq_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  logic ack, wr_c, wr_t, rd_c, rd_t;
  logic hv_q, ai_q, st_ok, ab_ok, ai_ok;
  logic [2:0] msk;
  logic [9:0] cnt;
  assign ack = psel && penable && pready;
  assign wr_c = ack && pwrite && paddr == 12'h000;
  assign wr_t = ack && pwrite && paddr == 12'h004;
  assign rd_c = ack && !pwrite && paddr == 12'h000;
  assign rd_t = ack && !pwrite && paddr == 12'h004;
  // Cycles since the last write; saturates so long waits never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_q <= 1'b0;
      ai_q <= 1'b0;
      st_ok <= 1'b0;
      ab_ok <= 1'b0;
      ai_ok <= 1'b0;
      msk <= 3'h0;
      cnt <= 10'h000;
    end else if (ack && pwrite) begin
      cnt <= 10'h000;
      st_ok <= wr_c && pwdata[0] && !hv_q && !pwdata[6];
      ab_ok <= wr_c && !pwdata[0] && hv_q;
      ai_ok <= wr_t && ai_q && (!pwdata[0] || pwdata[1]) && !pwdata[4];
      if (wr_c) hv_q <= pwdata[0];
      if (wr_t) ai_q <= pwdata[0];
      if (paddr == 12'h010) msk <= pwdata[2:0];
    end else if (cnt != 10'h3ff) begin
      cnt <= cnt + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence acc_start;
    psel && !penable ##1 psel && penable;
  endsequence
  ready_wait_a: assert property (acc_start |=> pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_unmapped_a: assert property (ack && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access not refused");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  irq_masked_a: assert property (msk == 3'h0 && $past(msk) == 3'h0 |-> !irq)
    else $error("irq with all masked");
  start_done_a: assert property (rd_c && st_ok && cnt < 10'd150 |-> !prdata[7])
    else $error("done not cleared by start");
  abort_done_a: assert property (rd_c && ab_ok && cnt > 10'd510 |-> prdata[7])
    else $error("done not set after abort");
  ai_stop_a: assert property (rd_t && ai_ok && cnt > 10'd52 |-> prdata[6])
    else $error("integrity done late on stop");
endmodule // fos_seq_checker
`default_nettype wire

/* test/fos_seq_bench.sv */
// Self-checking bench of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fos_seq_bench;
  // Short tick keeps the long program and erase counts within the run
  localparam int unsigned TK = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  fos_seq #(.TICK_CYC(TK)) fos_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Starts one edge late so a release and the next setup never share a step
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic poll(input logic [11:0] a, input int b, input int lim, input string nm);
    int t0;
    t0 = cyc;
    do bus(1'b0, a, 32'h0); while (rd[b] !== 1'b1 && cyc - t0 < lim);
    chk(nm, 32'h1, {31'h0, rd[b]});
  endtask
  task automatic run_op(input fos_pkg::fos_op_t op, input int us);
    wr(12'h000, {28'h0, op, 1'b1});
    rdc("done_clear", 12'h000, 32'h80, 32'h0);
    poll(12'h000, 7, us * TK, "op_done");
    wr(12'h000, {28'h0, op, 1'b0});
  endtask
  task automatic abort_op(input fos_pkg::fos_op_t op, input logic [1:0] bs);
    wr(12'h000, {26'h0, bs, op, 1'b1});
    wr(12'h000, {26'h0, bs, op, 1'b0});
    repeat (480) @(posedge pclk);
    rdc("abort_early", 12'h000, 32'h80, 32'h0);
    poll(12'h000, 7, 3 * 2204, "abort_done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl_rst", 12'h000, 32'hffffffff, 32'h180);
    rdc("test_rst", 12'h004, 32'hffffffff, 32'h140);
    rdc("wait_rst", 12'h008, 32'hffffffff, 32'h7);
    rdc("mask_rst", 12'h010, 32'hffffffff, 32'h0);
    wr(12'h014, 32'h5);
    chk("unmapped_err", 32'h1, {31'h0, er});
    for (int i = 1; i <= 7; i++) begin
      wr(12'h008, i);
      rdc("wait_states", 12'h008, 32'h7, i);
    end
    wr(12'h010, 32'h7);
    run_op(fos_pkg::FOS_OP_DWORD, 150);
    chk("irq_on", 32'h1, {31'h0, irq});
    rdc("stat_op", 12'h00c, 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(12'h010, 32'h0);
    run_op(fos_pkg::FOS_OP_PAGE, 171);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("stat_masked", 12'h00c, 32'h1, 32'h1);
    run_op(fos_pkg::FOS_OP_QPAGE, 450);
    run_op(fos_pkg::FOS_OP_SERS, 30000);
    abort_op(fos_pkg::FOS_OP_SPGM, 2'h0);
    for (int s = 0; s < 4; s++) abort_op(fos_pkg::FOS_OP_BERS, s[1:0]);
    wr(12'h000, 32'h40);
    rdc("lp_busy", 12'h000, 32'h100, 32'h0);
    wr(12'h000, 32'h0);
    repeat (1380) @(posedge pclk);
    rdc("rcv_early", 12'h000, 32'h100, 32'h0);
    poll(12'h000, 8, 720, "rcv_done");
    rdc("stat_rcv", 12'h00c, 32'h4, 32'h4);
    wr(12'h004, 32'h201);
    rdc("ai_clear", 12'h004, 32'h40, 32'h0);
    poll(12'h004, 6, 16392, "ai_seq");
    wr(12'h004, 32'h200);
    wr(12'h004, 32'h111);
    poll(12'h004, 6, 12200, "mr_seq");
    // Enable must fall first: a run starts only on its rising edge
    wr(12'h004, 32'h110);
    wr(12'h004, 32'h111);
    rdc("mr_clear", 12'h004, 32'h40, 32'h0);
    wr(12'h004, 32'h110);
    // Two reads of slack: done may land just after a poll read launched
    poll(12'h004, 6, 2623, "mr_stop");
    wr(12'h004, 32'h109);
    wr(12'h004, 32'h10b);
    poll(12'h004, 6, 50, "ai_susp");
    wr(12'h004, 32'h109);
    rdc("ai_resume", 12'h004, 32'h40, 32'h0);
    wr(12'h004, 32'h108);
    poll(12'h004, 6, 50, "ai_abort");
    wr(12'h004, 32'h121);
    poll(12'h004, 6, 4104, "ai_bp_halt");
    wr(12'h004, 32'h125);
    rdc("ai_bp_resume", 12'h004, 32'h40, 32'h0);
    poll(12'h004, 6, 4104, "ai_bp_end");
    give_verdict();
  end
  // Whole sequence needs about 60k cycles
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule // fos_seq_bench
bind fos_seq fos_seq_checker fos_seq_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
